// ==== lce_defs.svh ====
// Offsets, field positions, reset values and rate counts of the calibration block
`ifndef LCE_DEFS_SVH
`define LCE_DEFS_SVH

// Register byte offsets
`define LCE_MODE_OFS        8'h00
`define LCE_IRQ_EN_OFS      8'h04
`define LCE_IRQ_STAT_OFS    8'h08
`define LCE_HALF_CYC_OFS    8'h0C
`define LCE_PULSE_DIV_OFS   8'h10
`define LCE_GAIN_OFS        8'h14
`define LCE_PHASE_OFS       8'h18
`define LCE_ENERGY_LO_OFS   8'h1C
`define LCE_ENERGY_HI_OFS   8'h20
`define LCE_CAL_STAT_OFS    8'h24

// Field positions
`define LCE_CAL_MODE_BIT    7
`define LCE_WAV_SEL_LSB     13
`define LCE_SAG_BIT         0

// Reset values
`define LCE_MODE_RST        16'h0000
`define LCE_HALF_CYC_RST    8'hFF
`define LCE_PULSE_DIV_RST   12'h03F
`define LCE_GAIN_RST        12'h000
`define LCE_PHASE_RST       6'h00

// Rate counts in master clock cycles, the two divider counts given as period minus one, then the phase and gain shifts
`define LCE_ENERGY_DIV_M1   11'h003
`define LCE_WAVE_BASE_M1    11'h07F
`define LCE_PHASE_STEP      4
`define LCE_GAIN_SHIFT      12

`endif

// ==== lce_pkg.sv ====
// Types shared by the calibration block
package lce_pkg;

  // One register access from the plain software port
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lce_bus_req_type;

  // Calibration sequencer states
  typedef enum logic [2:0] {
    LCE_IDLE    = 3'b001,
    LCE_WAIT_ZX = 3'b010,
    LCE_ACCUM   = 3'b100
  } lce_state_type;

endpackage : lce_pkg

// ==== lce_rate_div.sv ====
// Programmable divider giving a one-cycle enable pulse
`timescale 1ns/10ps
module lce_rate_div (
  input  wire logic        clock,      // Master clock
  input  wire logic        rst_n,      // Asynchronous reset, active low
  input  wire logic [10:0] period_m1,  // Divide ratio minus one
  output logic             tick        // One-cycle enable pulse
);

  logic [10:0] count_reg;

  // Count up and wrap; a lowered ratio wraps at once instead of running on
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 11'h000;
    end else if (count_reg >= period_m1) begin
      count_reg <= 11'h000;
    end else begin
      count_reg <= count_reg + 11'h001;
    end
  end

  assign tick = (count_reg >= period_m1);

endmodule : lce_rate_div

// ==== lce_calib.sv ====
// Line-cycle energy calibration, pulse output and derived rates
// What this block does
// - Calibration mode runs while mode bit 7 set
// - Voltage channel zero crossings delimit half-cycles
// - Accumulate exactly the programmed half-cycle count, a count of zero as one
// - Up to 255 half-cycles per calibration
// - Cycle end sets sag flag, sag pin low
// - Enabled sag interrupt also pulls request low
// - Next calibration starts at once while mode set
// - Pulse output divided by divider plus one
// - Gain trim step is one part in 4096
// - Gain trim is 12-bit two's complement
// - Energy accumulator updates every four clocks
// - Waveform rate select picks clock/128 to /1024
// - Phase trim step is sixteen clock periods
// - Channel sampling at clock/4, Nyquist clock/8
// - Filter rates scale with the master clock
// - Register port timed by the master clock, read data a cycle after strobe
// - 24-bit accumulator MSB rise makes pulse
// - Energy accumulator is 40-bit signed sum
// - Pulse divider resets to 3Fh
`timescale 1ns/10ps
`include "lce_defs.svh"
module lce_calib (
  input  wire logic        clock,          // Master clock, 100 MHz
  input  wire logic        rst_n,          // Asynchronous reset, active low
  input  wire logic [7:0]  reg_addr,       // Register byte address
  input  wire logic [31:0] reg_wdata,      // Register write data
  input  wire logic        reg_wr,         // Write strobe
  input  wire logic        reg_rd,         // Read strobe
  output logic      [31:0] reg_rdata,      // Read data, cycle after strobe
  input  wire logic [19:0] active_power,   // Signed filtered active power
  input  wire logic        voltage_sign,   // Sign of voltage channel sample
  output logic             sample_en,      // Channel sample enable, clock/4
  output logic             wave_sample_en, // Waveform sample enable
  output logic             phase_strobe,   // Phase-trimmed sample enable
  output logic             zero_cross_out, // Line polarity square wave
  output logic             energy_pulse_out, // Divided energy pulse
  output logic             sag_out,        // Sag pin level, always low
  output logic             sag_oe,         // Sag pin pull-down enable
  output logic             irq_out,        // Request pin level, always low
  output logic             irq_oe          // Request pin pull-down enable
);

  lce_pkg::lce_bus_req_type req;
  lce_pkg::lce_state_type   state_reg;

  logic [15:0]        mode_reg;
  logic               sag_en_reg;
  logic               sag_flag_reg;
  logic [7:0]         half_cycle_count_reg;
  logic [11:0]        pulse_divider_reg;
  logic signed [11:0] power_gain_trim_reg;
  logic [5:0]         phase_trim_reg;
  logic signed [39:0] energy_acc_reg;
  logic signed [39:0] cal_result_reg;
  logic [23:0]        pulse_acc_reg;
  logic [11:0]        div_count_reg;
  logic [7:0]         half_count_reg;
  logic               sign_reg;
  logic [9:0]         phase_count_reg;
  logic               calibration_mode_bit;
  logic [1:0]         waveform_rate_select;
  logic               energy_tick;
  logic [10:0]        wave_period_m1;
  logic               zero_cross;
  logic               cal_done;
  logic               cal_restart;
  logic               msb_rise;
  logic signed [31:0] gain_product;
  logic signed [21:0] adj_power;
  logic [23:0]        pulse_acc_next;
  logic               sag_clear;

  // Bundle the port for decoding
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  assign calibration_mode_bit = mode_reg[`LCE_CAL_MODE_BIT];
  assign waveform_rate_select = mode_reg[`LCE_WAV_SEL_LSB +: 2];

  // Energy update tick, also the channel sample enable
  lce_rate_div u_energy_div (
    .clock     (clock),
    .rst_n     (rst_n),
    .period_m1 (`LCE_ENERGY_DIV_M1),
    .tick      (energy_tick)
  );

  // Each select step doubles the waveform period
  assign wave_period_m1 = ((`LCE_WAVE_BASE_M1 + 11'h001) << waveform_rate_select) - 11'h001;

  lce_rate_div u_wave_div (
    .clock     (clock),
    .rst_n     (rst_n),
    .period_m1 (wave_period_m1),
    .tick      (wave_sample_en)
  );

  // Sampling at clock/4 puts Nyquist at clock/8; every rate here is a count of
  // master clocks, so filter corners move with the clock rate
  assign sample_en = energy_tick;

  // Register writes; the port is single-cycle on the master clock, so its timing scales with the clock rate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg             <= `LCE_MODE_RST;
      sag_en_reg           <= 1'b0;
      half_cycle_count_reg <= `LCE_HALF_CYC_RST;
      pulse_divider_reg    <= `LCE_PULSE_DIV_RST;
      power_gain_trim_reg  <= `LCE_GAIN_RST;
      phase_trim_reg       <= `LCE_PHASE_RST;
    end else if (req.wr) begin
      case (req.addr)
        `LCE_MODE_OFS:      mode_reg <= req.wdata[15:0];
        `LCE_IRQ_EN_OFS:    sag_en_reg <= req.wdata[`LCE_SAG_BIT];
        `LCE_HALF_CYC_OFS:  half_cycle_count_reg <= req.wdata[7:0];
        `LCE_PULSE_DIV_OFS: pulse_divider_reg <= req.wdata[11:0];
        `LCE_GAIN_OFS:      power_gain_trim_reg <= req.wdata[11:0];
        `LCE_PHASE_OFS:     phase_trim_reg <= req.wdata[5:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (req.rd) begin
      case (req.addr)
        `LCE_MODE_OFS:      reg_rdata <= {16'h0000, mode_reg};
        `LCE_IRQ_EN_OFS:    reg_rdata <= {31'h0000_0000, sag_en_reg};
        `LCE_IRQ_STAT_OFS:  reg_rdata <= {31'h0000_0000, sag_flag_reg};
        `LCE_HALF_CYC_OFS:  reg_rdata <= {24'h00_0000, half_cycle_count_reg};
        `LCE_PULSE_DIV_OFS: reg_rdata <= {20'h0_0000, pulse_divider_reg};
        `LCE_GAIN_OFS:      reg_rdata <= {20'h0_0000, power_gain_trim_reg};
        `LCE_PHASE_OFS:     reg_rdata <= {26'h000_0000, phase_trim_reg};
        `LCE_ENERGY_LO_OFS: reg_rdata <= calibration_mode_bit ? cal_result_reg[31:0]
                                                                : energy_acc_reg[31:0];
        `LCE_ENERGY_HI_OFS: reg_rdata <= {24'h00_0000, calibration_mode_bit ?
                                          cal_result_reg[39:32] : energy_acc_reg[39:32]};
        `LCE_CAL_STAT_OFS:  reg_rdata <= {21'h00_0000, state_reg, half_count_reg};
        default:            reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Gain trim: one step is 1/4096 of the power, about 0.0244 percent.
  // Both operands are signed, so a negative trim or power is not read as a large one
  assign gain_product = 32'($signed(active_power) * power_gain_trim_reg);
  assign adj_power = 22'($signed(active_power)) + 22'(gain_product >>> `LCE_GAIN_SHIFT);

  // Polarity of the voltage channel, sampled at the channel rate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sign_reg <= 1'b0;
    end else if (energy_tick) begin
      sign_reg <= voltage_sign;
    end
  end

  // Either direction of change is a half-cycle boundary
  assign zero_cross = energy_tick && (voltage_sign != sign_reg);
  assign zero_cross_out = sign_reg;

  // A count of zero behaves as one; at zero or one the first boundary ends the cycle
  assign cal_done = (state_reg == lce_pkg::LCE_ACCUM) && zero_cross &&
                    (half_count_reg + 8'h01 >= half_cycle_count_reg);
  // Cycle begins on the first boundary, or again right after a completed one
  assign cal_restart = ((state_reg == lce_pkg::LCE_WAIT_ZX) && zero_cross) || cal_done;

  // Calibration sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= lce_pkg::LCE_IDLE;
    end else if (!calibration_mode_bit) begin
      state_reg <= lce_pkg::LCE_IDLE;
    end else begin
      case (state_reg)
        lce_pkg::LCE_IDLE:    state_reg <= lce_pkg::LCE_WAIT_ZX;
        lce_pkg::LCE_WAIT_ZX: if (zero_cross) state_reg <= lce_pkg::LCE_ACCUM;
        lce_pkg::LCE_ACCUM:   state_reg <= lce_pkg::LCE_ACCUM;
        default:              state_reg <= lce_pkg::LCE_IDLE;
      endcase
    end
  end

  // Half-cycle counter within a calibration cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_count_reg <= 8'h00;
    end else if (!calibration_mode_bit || cal_restart) begin
      half_count_reg <= 8'h00;
    end else if ((state_reg == lce_pkg::LCE_ACCUM) && zero_cross) begin
      half_count_reg <= half_count_reg + 8'h01;
    end
  end

  // Energy accumulator: free running outside calibration, gated inside it.
  // Every result, the first after entry too, starts cleared on a boundary tick, never mid-sample.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      energy_acc_reg <= 40'sh00_0000_0000;
    end else if (cal_restart) begin
      energy_acc_reg <= 40'sh00_0000_0000;
    end else if (energy_tick && (!calibration_mode_bit ||
                 state_reg == lce_pkg::LCE_ACCUM)) begin
      energy_acc_reg <= energy_acc_reg + 40'(adj_power);
    end
  end

  // Snapshot each finished cycle before the clear wipes it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cal_result_reg <= 40'sh00_0000_0000;
    end else if (cal_done) begin
      cal_result_reg <= energy_tick ? energy_acc_reg + 40'(adj_power) : energy_acc_reg;
    end
  end

  // Sag flag: write one to clear, a completion in the same cycle wins
  assign sag_clear = req.wr && (req.addr == `LCE_IRQ_STAT_OFS) && req.wdata[`LCE_SAG_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sag_flag_reg <= 1'b0;
    end else if (cal_done) begin
      sag_flag_reg <= 1'b1;
    end else if (sag_clear) begin
      sag_flag_reg <= 1'b0;
    end
  end

  // Open-drain pins only ever pull low
  assign sag_out = 1'b0;
  assign sag_oe  = sag_flag_reg;
  assign irq_out = 1'b0;
  assign irq_oe  = sag_flag_reg && sag_en_reg;

  // Frequency accumulator; only its MSB edge matters, so wrap is harmless
  assign pulse_acc_next = pulse_acc_reg + 24'(adj_power);
  assign msb_rise = energy_tick && !pulse_acc_reg[23] && pulse_acc_next[23];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulse_acc_reg <= 24'h00_0000;
    end else if (energy_tick) begin
      pulse_acc_reg <= pulse_acc_next;
    end
  end

  // Divide raw pulses by divider plus one
  // A divider write restarts the count, so an old count never outruns a new ratio
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_count_reg    <= 12'h000;
      energy_pulse_out <= 1'b0;
    end else begin
      energy_pulse_out <= 1'b0;
      if (req.wr && (req.addr == `LCE_PULSE_DIV_OFS)) begin
        div_count_reg <= 12'h000;
      end else if (msb_rise) begin
        if (div_count_reg >= pulse_divider_reg) begin
          div_count_reg    <= 12'h000;
          energy_pulse_out <= 1'b1;
        end else begin
          div_count_reg <= div_count_reg + 12'h001;
        end
      end
    end
  end

  // Phase trim delays the waveform sample by 16 clocks per step; a new
  // waveform tick restarts a delay still running
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_count_reg <= 10'h000;
      phase_strobe    <= 1'b0;
    end else begin
      phase_strobe <= 1'b0;
      if (wave_sample_en) begin
        phase_count_reg <= {phase_trim_reg, 4'h0};
        phase_strobe    <= (phase_trim_reg == 6'h00);
      end else if (phase_count_reg != 10'h000) begin
        phase_count_reg <= phase_count_reg - 10'h001;
        phase_strobe    <= (phase_count_reg == 10'h001);
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  energy_rate_a: assert property (energy_tick |=> !energy_tick [*3] ##1 energy_tick)
    else $error("energy update not every four clocks");
  mode_exit_a: assert property (!calibration_mode_bit |=> state_reg == lce_pkg::LCE_IDLE)
    else $error("sequencer active without calibration mode");
  sag_set_a: assert property (cal_done |=> sag_flag_reg && sag_oe && !sag_out)
    else $error("sag flag or pin missed at cycle end");
  irq_drive_a: assert property (cal_done && sag_en_reg |=> irq_oe && !irq_out)
    else $error("interrupt not driven at cycle end");
  cal_restart_a: assert property (cal_done && calibration_mode_bit
                                  |=> state_reg == lce_pkg::LCE_ACCUM && half_count_reg == 8'h00)
    else $error("new calibration cycle did not start");
  acc_clear_a: assert property (cal_restart |=> energy_acc_reg == 40'sh00_0000_0000)
    else $error("energy not cleared at cycle start");
  half_limit_a: assert property (state_reg == lce_pkg::LCE_ACCUM && half_cycle_count_reg != 8'h00
                                 |-> half_count_reg < half_cycle_count_reg)
    else $error("half-cycle count overran");
  pulse_div_a: assert property (energy_pulse_out
                                |-> $past(div_count_reg) == $past(pulse_divider_reg))
    else $error("pulse out not on divider match");
  phase_delay_a: assert property (wave_sample_en && phase_trim_reg == 6'h02
                                  && wave_period_m1 > 11'h021 |-> ##33 phase_strobe)
    else $error("phase strobe not sixteen clocks per step late");
  zc_edge_a: assert property (zero_cross |=> zero_cross_out == $past(voltage_sign))
    else $error("zero crossing not tracked");
  // Entry steps, pulse width and the sign of the gain trim
  idle_step_a: assert property (state_reg == lce_pkg::LCE_IDLE && calibration_mode_bit
                                |=> state_reg == lce_pkg::LCE_WAIT_ZX)
    else $error("sequencer did not leave idle");
  first_cross_a: assert property (state_reg == lce_pkg::LCE_WAIT_ZX && zero_cross &&
                                  calibration_mode_bit
                                  |=> state_reg == lce_pkg::LCE_ACCUM && half_count_reg == 8'h00)
    else $error("calibration did not start on a zero crossing");
  pulse_single_a: assert property (energy_pulse_out |=> !energy_pulse_out)
    else $error("energy pulse longer than one clock");
  gain_sign_a: assert property (power_gain_trim_reg[11] && !active_power[19]
                                && |active_power |-> adj_power < 22'($signed(active_power)))
    else $error("negative gain trim did not lower the power");

  cal_done_c: cover property (cal_done ##1 state_reg == lce_pkg::LCE_ACCUM);
  gain_c:     cover property (power_gain_trim_reg[11] && energy_tick);
  pulse_c:    cover property (energy_pulse_out);
  irq_c:      cover property ($rose(irq_oe));
  clear_c:    cover property (sag_flag_reg ##1 !sag_flag_reg);

endmodule : lce_calib

// ==== lce_line_model.sv ====
// Line voltage source, power source and pulse counter facing the calibration block
`timescale 1ns/10ps
module lce_line_model #(
  parameter int HALF_CLKS = 64                // Clocks per line half-cycle
) (
  input  wire logic        clock,             // Master clock
  input  wire logic        rst_n,             // Asynchronous reset, active low
  input  wire logic [19:0] power_level,       // Power value to present
  input  wire logic        energy_pulse_out,  // Divided energy pulse from the block
  output logic             voltage_sign,      // Voltage channel polarity
  output logic      [19:0] active_power,      // Filtered power sample
  output int               pulse_count        // Pulses seen so far
);
  int half_cnt;

  // Line runs free: mains never stops between calibrations
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt     <= 0;
      voltage_sign <= 1'b0;
    end else if (half_cnt == HALF_CLKS - 1) begin
      half_cnt     <= 0;
      voltage_sign <= ~voltage_sign;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end

  // Steady load keeps every expected energy an exact product
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_power <= 20'h00000;
      pulse_count  <= 0;
    end else begin
      active_power <= power_level;
      if (energy_pulse_out === 1'b1)
        pulse_count <= pulse_count + 1;
    end
  end
endmodule : lce_line_model

// ==== tb_top.sv ====
// Self-checking bench for the line-cycle energy calibration block
`timescale 1ns/10ps
`include "lce_defs.svh"
module tb_top;
  localparam int HALF = 64;                   // Clocks per half-cycle, a multiple of four
  localparam int PWR  = 32'h40000;            // One pulse-accumulator wrap per 64 updates

  logic        clock;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [19:0] power_level;
  logic [19:0] active_power;
  logic        voltage_sign;
  logic        sample_en;
  logic        wave_sample_en;
  logic        phase_strobe;
  logic        zero_cross_out;
  logic        energy_pulse_out;
  logic        sag_out;
  logic        sag_oe;
  logic        irq_out;
  logic        irq_oe;
  logic [3:0]  watch;
  int          pulse_count;
  int          cyc = 0;
  int          err_count;
  int          check_count;
  int          a;
  int          b;
  int          n;
  logic [7:0]  ra [7] = '{`LCE_MODE_OFS, `LCE_IRQ_EN_OFS, `LCE_HALF_CYC_OFS,
                          `LCE_PULSE_DIV_OFS, `LCE_GAIN_OFS, `LCE_PHASE_OFS, 8'h30};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'hFF, 32'h3F, 32'h0, 32'h0, 32'h0};
  int          nh [2] = '{1, 3};

  lce_calib i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .active_power(active_power),
    .voltage_sign(voltage_sign), .sample_en(sample_en), .wave_sample_en(wave_sample_en),
    .phase_strobe(phase_strobe), .zero_cross_out(zero_cross_out),
    .energy_pulse_out(energy_pulse_out), .sag_out(sag_out), .sag_oe(sag_oe),
    .irq_out(irq_out), .irq_oe(irq_oe));

  lce_line_model #(.HALF_CLKS(HALF)) i_line (.clock(clock), .rst_n(rst_n),
    .power_level(power_level), .energy_pulse_out(energy_pulse_out),
    .voltage_sign(voltage_sign), .active_power(active_power), .pulse_count(pulse_count));

  // Strobes watched by the bounded wait task, selected by index
  assign watch = {phase_strobe, wave_sample_en, energy_pulse_out, sag_oe};

  // 100 MHz master clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Cycle stamp, so intervals are exact clock counts
  always @(posedge clock) begin
    cyc <= cyc + 1;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clock);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data appears in the cycle after the strobe and holds until the next read
  task automatic rdchk(input logic [7:0] addr, input logic [39:0] exp);
    @(posedge clock);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, exp);
  endtask : rdchk

  // Wait for a watched strobe, but never forever
  task automatic wait_sig(input int sel, output int at);
    at = -1;
    for (int i = 0; i < 5000 && at < 0; i++) begin
      @(posedge clock);
      #1;
      if (watch[sel] === 1'b1)
        at = cyc;
    end
    if (at < 0)
      chk(40'h0, 40'h1);
  endtask : wait_sig

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Hang guard at 40k cycles, well beyond the roughly 9.5k cycles the tests take
  initial begin
    #400000;
    err_count++;
    conclude();
  end

  initial begin
    err_count = 0; check_count = 0;
    rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    power_level = PWR[19:0];
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
      rdchk(ra[i], {8'h00, rv[i]});
    wr(`LCE_GAIN_OFS, 32'hFEF);
    rdchk(`LCE_GAIN_OFS, 40'hFEF);
    wr(8'h30, 32'hFFFF_FFFF);
    rdchk(8'h30, 40'h0);
    wr(`LCE_GAIN_OFS, 32'h0);
    // Update enable must fire once in every four clocks
    n = 0;
    repeat (40) begin
      @(posedge clock);
      #1;
      if (sample_en === 1'b1)
        n++;
    end
    chk(40'(n), 40'd10);
    for (int s = 0; s < 4; s++) begin
      wr(`LCE_MODE_OFS, 32'(s) << `LCE_WAV_SEL_LSB);
      wait_sig(2, a);
      wait_sig(2, a);
      wait_sig(2, b);
      chk(40'(b - a), 40'(128 << s));
    end
    wr(`LCE_MODE_OFS, 32'h0);
    wr(`LCE_PHASE_OFS, 32'h2);
    wait_sig(2, a);
    wait_sig(3, b);
    chk(40'(b - a), 40'd33);
    // Mid half-cycle the polarity output must follow the line
    @(posedge voltage_sign);
    repeat (8) @(posedge clock);
    #1;
    chk(40'(zero_cross_out), 40'(voltage_sign));
    for (int d = 0; d < 3; d += 2) begin
      wr(`LCE_PULSE_DIV_OFS, 32'(d));
      wait_sig(1, a);
      wait_sig(1, a);
      wait_sig(1, b);
      chk(40'(b - a), 40'(256 * (d + 1)));
    end
    chk(40'(pulse_count > 0), 40'h1);
    // Calibration with a one and a three half-cycle span, request pin off then on
    for (int k = 0; k < 2; k++) begin
      wr(`LCE_HALF_CYC_OFS, 32'(nh[k]));
      wr(`LCE_IRQ_EN_OFS, 32'(k));
      wr(`LCE_GAIN_OFS, 32'(k) * 32'hFEF);
      wr(`LCE_IRQ_STAT_OFS, 32'h1);
      wr(`LCE_MODE_OFS, 32'h80);
      wait_sig(0, a);
      chk(40'(sag_out), 40'h0);
      chk(40'(irq_oe), 40'(k));
      chk(40'(irq_out), 40'h0);
      wr(`LCE_IRQ_STAT_OFS, 32'h1);
      chk(40'(sag_oe), 40'h0);
      chk(40'(irq_oe), 40'h0);
      wait_sig(0, b);
      chk(40'(b - a), 40'(nh[k] * HALF));
      // Trim of minus 17 steps takes 17/4096 off every sample
      n = nh[k] * (HALF / 4) * (PWR - k * 17 * (PWR / 4096));
      rdchk(`LCE_ENERGY_LO_OFS, 40'(n));
      rdchk(`LCE_ENERGY_HI_OFS, 40'h0);
      wr(`LCE_MODE_OFS, 32'h0);
      wr(`LCE_IRQ_STAT_OFS, 32'h1);
    end
    conclude();
  end
endmodule : tb_top
